// File: rtl/ifs_filter_stop_range.sv
// i2c input glitch filter, bus stop detect, stop-mode holdoff and range address match
// assumes one 200 MHz clock MCLK, synchronous reset, and a transfer core on the same clock
`timescale 1ns/10ps
`include "ifs_regs.svh"
// Behaviour
// - holdoff on and module idle: stop-mode request acknowledged immediately.
// - holdoff on during a transfer: acknowledge after the current byte finishes.
// - module irq enable set before stop: transfer-complete interrupt after wake.
// - holdoff off never gates stop entry; holdoff on applies holdoff.
// - bus stop sets flag bit 6; stays until software writes one.
// - stop irq enable bit 5 gates the bus stop interrupt via the module flag; stop status bit 2 sets regardless.
// - clear stop flag before module flag, else module flag reasserts.
// - filter blocks pulses no longer than the programmed setting in bits 4-0.
// - setting zero bypasses; 1 to 31 suppress glitches up to n cycles. Here zero still drops one-cycle pulses, and n+1-cycle pulses are dropped too.
// - range register bits 7-1 hold a 7-bit address, 7-bit scheme only.
// - nonzero range register enables it; zero keeps it out of matching.
// - range register matches like primary address, and is upper bound in range mode.
// - range mode matches addresses above primary and at or below range.
// - range register bit 0 reads zero, ignores writes.
module ifs_filter_stop_range (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // axi4-lite write address and data
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    // axi4-lite write response
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    output logic [1:0]       S_AXI_BRESP,
    // axi4-lite read
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    // i2c bus inputs and filtered levels
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SCL_FILT,
    output logic             SDA_FILT,
    // transfer core
    input  wire logic        XFER_BUSY,
    input  wire logic        BYTE_DONE,
    input  wire logic        TCF_IN,
    input  wire logic        ADDR_10BIT,
    input  wire logic        ADDR_VALID,
    input  wire logic [6:0]  RX_ADDR,
    output logic             ADDR_MATCH,
    // low-power controller
    input  wire logic        STOP_REQ,
    output logic             STOP_ACK,
    // interrupt
    output logic             IRQ
);

    // address decode: register index from a byte address
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic known_index(input logic [7:0] idx);
        known_index = (idx == 8'(`IFS_IDX_FLT)) || (idx == 8'(`IFS_IDX_RA)) ||
                      (idx == 8'(`IFS_IDX_CTRL)) || (idx == 8'(`IFS_IDX_IRQ_STAT)) ||
                      (idx == 8'(`IFS_IDX_IRQ_CLR)) || (idx == 8'(`IFS_IDX_IRQ_EN));
    endfunction

    // register state
    ifs_pkg::ifs_byte_t flt_reg;
    ifs_pkg::ifs_byte_t ra_reg;
    ifs_pkg::ifs_byte_t ctrl_reg;
    logic [2:0]         irq_stat_reg;
    logic [2:0]         irq_en_reg;
    logic               irq_reg;

    // axi slave state
    logic               aw_full_reg;
    logic               w_full_reg;
    logic [31:0]        aw_addr_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               aw_rdy_reg;
    logic               w_rdy_reg;
    logic               bvalid_reg;
    logic [1:0]         bresp_reg;
    logic               ar_rdy_reg;
    logic               rvalid_reg;
    logic [31:0]        rdata_reg;
    logic [1:0]         rresp_reg;

    // field views
    wire                stop_holdoff_enable         = flt_reg[`IFS_FLT_STOP_HOLDOFF_ENABLE_BIT];
    wire                stop_flag    = flt_reg[`IFS_FLT_BUS_STOP_FLAG_BIT];
    wire                stop_ie      = flt_reg[`IFS_FLT_STOP_IRQ_ENABLE_BIT];
    wire [4:0]          glitch_set   = flt_reg[`IFS_FLT_SET_MSB:0];
    wire [6:0]          range_addr   = ra_reg[7:1];
    wire [6:0]          prim_addr    = ctrl_reg[7:1];
    wire                range_mode   = ctrl_reg[`IFS_CTRL_RANGE_MATCH_ENABLE_BIT];
    wire                mod_irq_en   = irq_en_reg[`IFS_IRQ_MOD_BIT];

    // write channel: address and data taken in either order, answered after both
    wire                aw_hs        = S_AXI_AWVALID & aw_rdy_reg;
    wire                w_hs         = S_AXI_WVALID & w_rdy_reg;
    wire                do_wr        = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire [7:0]          wr_idx       = reg_index(aw_addr_reg);
    wire                wr_lane0     = do_wr & w_strb_reg[0];
    wire                wr_flt       = wr_lane0 & (wr_idx == 8'(`IFS_IDX_FLT));
    wire                wr_ra        = wr_lane0 & (wr_idx == 8'(`IFS_IDX_RA));
    wire                wr_ctrl      = wr_lane0 & (wr_idx == 8'(`IFS_IDX_CTRL));
    wire                wr_clr       = wr_lane0 & (wr_idx == 8'(`IFS_IDX_IRQ_CLR));
    wire                wr_en        = wr_lane0 & (wr_idx == 8'(`IFS_IDX_IRQ_EN));
    wire [7:0]          wbyte        = w_data_reg[7:0];
    wire                aw_full_next = (aw_full_reg | aw_hs) & ~do_wr;
    wire                w_full_next  = (w_full_reg | w_hs) & ~do_wr;
    wire                bvalid_next  = do_wr | (bvalid_reg & ~S_AXI_BREADY);

    // read channel: one read at a time, answered the cycle after it is taken
    wire                ar_hs        = S_AXI_ARVALID & ar_rdy_reg;
    wire [7:0]          rd_idx       = reg_index(S_AXI_ARADDR);
    wire                rvalid_next  = ar_hs | (rvalid_reg & ~S_AXI_RREADY);
    logic [7:0]         rd_byte;

    // read mux; the clear register reads as zero since it is write-only
    always_comb begin
        case (rd_idx)
            8'(`IFS_IDX_FLT):      rd_byte = flt_reg;
            8'(`IFS_IDX_RA):       rd_byte = {ra_reg[7:1], 1'b0};
            8'(`IFS_IDX_CTRL):     rd_byte = ctrl_reg;
            8'(`IFS_IDX_IRQ_STAT): rd_byte = {5'h00, irq_stat_reg};
            8'(`IFS_IDX_IRQ_EN):   rd_byte = {5'h00, irq_en_reg};
            default:               rd_byte = 8'h00;
        endcase
    end

    // axi handshake registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_rdy_reg  <= 1'b0;
            w_rdy_reg   <= 1'b0;
            bvalid_reg  <= 1'b0;
            ar_rdy_reg  <= 1'b0;
            rvalid_reg  <= 1'b0;
        end else begin
            aw_full_reg <= aw_full_next;
            w_full_reg  <= w_full_next;
            aw_rdy_reg  <= ~aw_full_next;
            w_rdy_reg   <= ~w_full_next;
            bvalid_reg  <= bvalid_next;
            ar_rdy_reg  <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
        end
    end

    // axi payload registers
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_addr_reg <= 32'h0000_0000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bresp_reg   <= `IFS_RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `IFS_RESP_OKAY;
        end else begin
            if (aw_hs) aw_addr_reg <= S_AXI_AWADDR;
            if (w_hs) w_data_reg <= S_AXI_WDATA;
            if (w_hs) w_strb_reg <= S_AXI_WSTRB;
            if (do_wr) bresp_reg <= known_index(wr_idx) ? `IFS_RESP_OKAY : `IFS_RESP_SLVERR;
            if (ar_hs) rdata_reg <= {24'h000000, rd_byte};
            if (ar_hs) rresp_reg <= known_index(rd_idx) ? `IFS_RESP_OKAY : `IFS_RESP_SLVERR;
        end
    end

    // input synchronisers: three stages, a level counts once stages two and three agree
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [1:0] filt_reg;
    logic [4:0] cnt_reg [2];
    logic [1:0] cnt_pass;
    logic [1:0] differ;
    logic       sda_filt_d_reg;

    // index 2 is the scl sample the filter reads, 1 is sda, 0 is scl again and nothing reads it
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            sync3_reg <= 3'h7;
        end else begin
            sync1_reg <= {SCL_IN, SDA_IN, SCL_IN};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a candidate level differs from the passed one; a settling input restarts the count
    assign differ[0] = (sync2_reg[2] == sync3_reg[2]) & (sync3_reg[2] != filt_reg[0]);
    assign differ[1] = (sync2_reg[1] == sync3_reg[1]) & (sync3_reg[1] != filt_reg[1]);
    // the level passes in its (setting+1)th stable cycle; setting 0 passes at once
    assign cnt_pass[0] = differ[0] & (cnt_reg[0] == glitch_set);
    assign cnt_pass[1] = differ[1] & (cnt_reg[1] == glitch_set);

    // glitch filter counters
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cnt_reg[0] <= 5'h00;
            cnt_reg[1] <= 5'h00;
            filt_reg   <= 2'h3;
        end else begin
            cnt_reg[0] <= (differ[0] & ~cnt_pass[0]) ? cnt_reg[0] + 5'h01 : 5'h00;
            cnt_reg[1] <= (differ[1] & ~cnt_pass[1]) ? cnt_reg[1] + 5'h01 : 5'h00;
            if (cnt_pass[0]) filt_reg[0] <= sync3_reg[2];
            if (cnt_pass[1]) filt_reg[1] <= sync3_reg[1];
        end
    end

    // stop condition: filtered sda rises while filtered scl is high
    wire stop_det = filt_reg[0] & filt_reg[1] & ~sda_filt_d_reg;

    always_ff @(posedge MCLK) begin
        if (RESET) sda_filt_d_reg <= 1'b1;
        else sda_filt_d_reg <= filt_reg[1];
    end

    // stop-mode holdoff
    ifs_pkg::ifs_hold_e hold_reg;
    ifs_pkg::ifs_hold_e hold_next;
    logic               wake_en_reg;
    wire                byte_free = ~XFER_BUSY | BYTE_DONE;

    always_comb begin
        case (hold_reg)
            ifs_pkg::IFS_RUN: begin
                if (!STOP_REQ) hold_next = ifs_pkg::IFS_RUN;
                else if (!stop_holdoff_enable || byte_free) hold_next = ifs_pkg::IFS_ACKED;
                else hold_next = ifs_pkg::IFS_WAIT_BYTE;
            end
            ifs_pkg::IFS_WAIT_BYTE: begin
                if (!STOP_REQ) hold_next = ifs_pkg::IFS_RUN;
                else if (!stop_holdoff_enable || byte_free) hold_next = ifs_pkg::IFS_ACKED;
                else hold_next = ifs_pkg::IFS_WAIT_BYTE;
            end
            ifs_pkg::IFS_ACKED: begin
                hold_next = STOP_REQ ? ifs_pkg::IFS_ACKED : ifs_pkg::IFS_RUN;
            end
            default: hold_next = ifs_pkg::IFS_RUN;
        endcase
    end

    // a wake is the request falling while acknowledged
    wire wake_evt  = (hold_reg == ifs_pkg::IFS_ACKED) & ~STOP_REQ;
    wire enter_evt = (hold_reg != ifs_pkg::IFS_ACKED) & (hold_next == ifs_pkg::IFS_ACKED);

    // the interrupt enable is caught at stop entry so software changes while asleep do not count
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            hold_reg    <= ifs_pkg::IFS_RUN;
            STOP_ACK    <= 1'b0;
            wake_en_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            STOP_ACK <= (hold_next == ifs_pkg::IFS_ACKED);
            if (enter_evt) wake_en_reg <= mod_irq_en;
        end
    end

    // address matching; range register only in the 7-bit scheme
    wire ra_on     = (range_addr != 7'h00) & ~ADDR_10BIT;
    wire hit_prim  = (RX_ADDR == prim_addr);
    wire hit_ra    = ra_on & (RX_ADDR == range_addr);
    wire hit_range = ra_on & range_mode & (RX_ADDR > prim_addr) & (RX_ADDR <= range_addr);
    wire match_evt = ADDR_VALID & (hit_prim | hit_ra | hit_range);

    always_ff @(posedge MCLK) begin
        if (RESET) ADDR_MATCH <= 1'b0;
        else ADDR_MATCH <= match_evt;
    end

    // interrupt sources; the module flag follows the stop flag as a level so clearing
    // it first only sees it come back
    wire [2:0] irq_set;
    assign irq_set[`IFS_IRQ_MOD_BIT]   = TCF_IN | (wake_evt & wake_en_reg) |
                                         (stop_flag & stop_ie);
    assign irq_set[`IFS_IRQ_MATCH_BIT] = match_evt;
    assign irq_set[`IFS_IRQ_STOP_BIT]  = stop_det;
    wire [2:0] irq_clr = wr_clr ? wbyte[2:0] : 3'h0;
    wire [2:0] irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);

    // software registers; hardware set wins over a same-cycle clear
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            flt_reg      <= `IFS_FLT_RESET;
            ra_reg       <= `IFS_RA_RESET;
            ctrl_reg     <= `IFS_CTRL_RESET;
            irq_stat_reg <= `IFS_IRQ_RESET;
            irq_en_reg   <= `IFS_IRQ_RESET;
            irq_reg      <= 1'b0;
        end else begin
            if (wr_flt) begin
                flt_reg[`IFS_FLT_STOP_HOLDOFF_ENABLE_BIT]    <= wbyte[`IFS_FLT_STOP_HOLDOFF_ENABLE_BIT];
                flt_reg[`IFS_FLT_STOP_IRQ_ENABLE_BIT]  <= wbyte[`IFS_FLT_STOP_IRQ_ENABLE_BIT];
                flt_reg[`IFS_FLT_SET_MSB:0]   <= wbyte[`IFS_FLT_SET_MSB:0];
            end
            flt_reg[`IFS_FLT_BUS_STOP_FLAG_BIT] <= stop_det | (stop_flag &
                ~(wr_flt & wbyte[`IFS_FLT_BUS_STOP_FLAG_BIT]));
            if (wr_ra) ra_reg <= wbyte & `IFS_RA_WMASK;
            if (wr_ctrl) ctrl_reg <= wbyte;
            if (wr_en) irq_en_reg <= wbyte[2:0];
            irq_stat_reg <= irq_stat_next;
            irq_reg      <= |(irq_stat_next & (wr_en ? wbyte[2:0] : irq_en_reg));
        end
    end

    // outputs
    assign S_AXI_AWREADY = aw_rdy_reg;
    assign S_AXI_WREADY  = w_rdy_reg;
    assign S_AXI_BVALID  = bvalid_reg;
    assign S_AXI_BRESP   = bresp_reg;
    assign S_AXI_ARREADY = ar_rdy_reg;
    assign S_AXI_RVALID  = rvalid_reg;
    assign S_AXI_RDATA   = rdata_reg;
    assign S_AXI_RRESP   = rresp_reg;
    assign SCL_FILT      = filt_reg[0];
    assign SDA_FILT      = filt_reg[1];
    assign IRQ           = irq_reg;

    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_idle_ack: assert property (
        hold_reg == ifs_pkg::IFS_RUN && STOP_REQ && stop_holdoff_enable && !XFER_BUSY |=> STOP_ACK)
        else $error("idle stop request not acknowledged at once");
    a_busy_hold: assert property (
        hold_reg == ifs_pkg::IFS_RUN && STOP_REQ && stop_holdoff_enable && XFER_BUSY && !BYTE_DONE
        |=> !STOP_ACK)
        else $error("stop acknowledged before the byte finished");
    a_no_gate: assert property (
        STOP_REQ && !stop_holdoff_enable |=> STOP_ACK)
        else $error("stop entry gated with holdoff off");
    a_wake_irq: assert property (
        wake_evt && wake_en_reg |=> irq_stat_reg[0])
        else $error("no transfer interrupt after wake");
    a_stop_flag: assert property (
        stop_det |=> stop_flag [*2])
        else $error("stop flag not set or not sticky");
    a_stop_gate: assert property (
        $rose(irq_stat_reg[0]) && !$past(TCF_IN) && !$past(wake_evt) |-> $past(stop_ie))
        else $error("stop interrupt raised while disabled");
    a_mod_reassert: assert property (
        stop_flag && stop_ie |=> irq_stat_reg[0])
        else $error("module flag stays clear while stop flag pending");
    a_glitch_pass: assert property (
        $changed(SDA_FILT) |-> $past(cnt_reg[1]) == $past(glitch_set))
        else $error("sda level passed before its stable time");
    a_ra_lsb: assert property (
        ra_reg[0] == 1'b0)
        else $error("range register bit 0 set");
    a_range_hit: assert property (
        ADDR_VALID && range_mode && !ADDR_10BIT && RX_ADDR > prim_addr &&
        RX_ADDR <= range_addr |=> ADDR_MATCH)
        else $error("address in range not matched");
    a_ra_off: assert property (
        ADDR_VALID && range_addr == 7'h00 && RX_ADDR != prim_addr |=> !ADDR_MATCH)
        else $error("zero range register took part in matching");

    c_hold_wait: cover property (hold_reg == ifs_pkg::IFS_WAIT_BYTE ##1 STOP_ACK);
    c_range: cover property (ADDR_VALID && hit_range && !hit_prim);
    c_stop: cover property (stop_det ##1 stop_flag);
    c_wake: cover property (wake_evt && wake_en_reg);

endmodule

// File: rtl/ifs_regs.svh
// register offsets, field positions and reset values of the filter/stop/range block
// assumes a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef IFS_REGS_SVH
`define IFS_REGS_SVH

// register indices; byte address is four times the index
`define IFS_IDX_FLT        6
`define IFS_IDX_RA         7
`define IFS_IDX_CTRL       16
`define IFS_IDX_IRQ_STAT   17
`define IFS_IDX_IRQ_CLR    18
`define IFS_IDX_IRQ_EN     19

// glitch filter control fields
`define IFS_FLT_STOP_HOLDOFF_ENABLE_BIT   7
`define IFS_FLT_BUS_STOP_FLAG_BIT  6
`define IFS_FLT_STOP_IRQ_ENABLE_BIT 5
`define IFS_FLT_SET_MSB    4
`define IFS_FLT_RESET      8'h00

// range address
`define IFS_RA_RESET       8'h00
`define IFS_RA_WMASK       8'hFE

// control: primary address in 7..1, range match enable in 0
`define IFS_CTRL_RANGE_MATCH_ENABLE_BIT  0
`define IFS_CTRL_RESET     8'h00

// interrupt status / clear / enable layout
`define IFS_IRQ_MOD_BIT    0
`define IFS_IRQ_MATCH_BIT  1
`define IFS_IRQ_STOP_BIT   2
`define IFS_IRQ_RESET      3'h0

// answers
`define IFS_RESP_OKAY      2'h0
`define IFS_RESP_SLVERR    2'h2

`endif

// File: rtl/ifs_pkg.sv
// types shared by the filter/stop/range block
// assumes nothing beyond a SystemVerilog compiler
package ifs_pkg;
    // stop-mode holdoff states
    typedef enum logic [1:0] {
        IFS_RUN,
        IFS_WAIT_BYTE,
        IFS_ACKED
    } ifs_hold_e;

    typedef logic [7:0] ifs_byte_t;
endpackage

// File: verification/ifs_bus_model.sv
// far-side model: another i2c master driving the open-drain lines
// assumes pull-ups on both lines, so a released line reads high; frames clock at 125 ns
`timescale 1ns/10ps
module ifs_bus_model (
    // bus lines as seen through the pull-ups
    output logic scl,
    output logic sda
);
    // both lines released at start
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // short low pulse on the clock line; data stays high so no start or stop is seen
    task automatic glitch(input int cyc);
        #1 scl = 1'b0;
        #(cyc * 5) scl = 1'b1;
    endtask

    // start, eight bits, released ack slot, stop; clock stands high between frames
    task automatic frame(input logic [7:0] b);
        logic [8:0] bits = {b, 1'b1};
        #1 sda = 1'b0;
        #62.5;
        for (int i = 8; i >= 0; i--) begin
            scl = 1'b0;
            #31.25 sda = bits[i];
            #31.25 scl = 1'b1;
            #62.5;
        end
        scl = 1'b0;
        #31.25 sda = 1'b0;
        #31.25 scl = 1'b1;
        #31.25 sda = 1'b1;
        #31.25;
    endtask
endmodule

// File: verification/ifs_filter_stop_range_tb.sv
// self-checking bench for the filter, stop detect, holdoff and range match block
// assumes the bus model drives the i2c lines; the bench plays bus master and transfer core
`timescale 1ns/10ps
`include "ifs_regs.svh"
module ifs_filter_stop_range_tb;
    localparam logic [31:0] A_FLT  = `IFS_IDX_FLT * 4;
    localparam logic [31:0] A_RA   = `IFS_IDX_RA * 4;
    localparam logic [31:0] A_CTRL = `IFS_IDX_CTRL * 4;
    localparam logic [31:0] A_STAT = `IFS_IDX_IRQ_STAT * 4;
    localparam logic [31:0] A_CLR  = `IFS_IDX_IRQ_CLR * 4;
    localparam logic [31:0] A_EN   = `IFS_IDX_IRQ_EN * 4;
    logic        mclk = 1'b0, reset = 1'b1, low_seen = 1'b0;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic        arready, rvalid, scl, sda, scl_filt, sda_filt, addr_match, stop_ack, irq;
    logic        xfer_busy, byte_done, tcf_in, addr_10bit, addr_valid, stop_req;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [6:0]  rx_addr;
    logic [4:0]  flt_set [4] = '{5'h00, 5'h01, 5'h04, 5'h1F};
    logic [7:0]  addr_tab [4] = '{8'h91, 8'h98, 8'h19, 8'h0F};
    int          err_total = 0, samples_checked = 0;

    // free-running clock and a sticky note of any low level on the filtered clock line
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) if (scl_filt === 1'b0) low_seen <= 1'b1;

    ifs_filter_stop_range dut_u (
        .MCLK(mclk), .RESET(reset), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .SCL_IN(scl), .SDA_IN(sda), .SCL_FILT(scl_filt), .SDA_FILT(sda_filt),
        .XFER_BUSY(xfer_busy), .BYTE_DONE(byte_done), .TCF_IN(tcf_in),
        .ADDR_10BIT(addr_10bit), .ADDR_VALID(addr_valid), .RX_ADDR(rx_addr),
        .ADDR_MATCH(addr_match), .STOP_REQ(stop_req), .STOP_ACK(stop_ack), .IRQ(irq));
    ifs_bus_model bus_u (.scl(scl), .sda(sda));

    // one comparison, counted; four-state equality so an unknown never matches
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // write: address and data offered together, each dropped when its ready is seen
    task automatic axi_wr(input logic [31:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bvalid && n < 50) begin
            @(posedge mclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        rs = bresp;
        bready <= 1'b0;
        chk("write_answered", n < 50, 1'b1);
    endtask

    // read: rready held from the start, data taken at the edge where rvalid is seen
    task automatic axi_rd(input logic [31:0] a);
        int n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rvalid && n < 50) begin
            @(posedge mclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        chk("read_answered", n < 50, 1'b1);
    endtask

    task automatic rchk(input logic [31:0] a, input logic [7:0] exp, input string nm);
        axi_rd(a);
        chk(nm, rd, {24'h000000, exp});
    endtask

    // a pulse of the setting is swallowed, one two cycles longer gets through
    task automatic filt_try(input logic [4:0] n);
        axi_wr(A_FLT, {3'b000, n});
        if (n != 5'h00) begin
            #1 low_seen = 1'b0;
            bus_u.glitch(n);
            repeat (2 * n + 12) @(posedge mclk);
            chk("glitch_blocked", low_seen, 1'b0);
        end
        #1 low_seen = 1'b0;
        bus_u.glitch(n + 2);
        repeat (2 * n + 12) @(posedge mclk);
        chk("level_passed", low_seen, 1'b1);
    endtask

    task automatic addr_try(input logic [6:0] a, input logic exp);
        @(posedge mclk);
        rx_addr <= a;
        addr_valid <= 1'b1;
        @(posedge mclk);
        addr_valid <= 1'b0;
        #1 chk("addr_match", addr_match, exp);
    endtask

    // hold is the number of edges the in-flight byte keeps the acknowledge back
    task automatic stop_try(input logic [7:0] f, input logic busy, input int hold);
        axi_wr(A_FLT, f);
        xfer_busy <= busy;
        stop_req <= 1'b1;
        repeat (hold) @(posedge mclk);
        if (hold > 0) begin
            #1 chk("ack_held", stop_ack, 1'b0);
            byte_done <= 1'b1;
        end
        @(posedge mclk);
        #1 chk("ack", stop_ack, 1'b1);
        byte_done <= 1'b0;
        xfer_busy <= 1'b0;
        stop_req <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("ack_drop", stop_ack, 1'b0);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #100000;
        err_total++;
        conclude();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = '0;
        {xfer_busy, byte_done, tcf_in, addr_10bit, addr_valid, stop_req, rx_addr} = '0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        rchk(A_FLT, 8'h00, "flt_reset");
        rchk(A_RA, 8'h00, "ra_reset");
        rchk(A_STAT, 8'h00, "stat_reset");
        axi_wr(A_RA, 8'hFF);
        rchk(A_RA, 8'hFE, "ra_bit0");
        axi_wr(32'h00000100, 8'h55);
        chk("unmapped_wr", rs, `IFS_RESP_SLVERR);
        rchk(32'h00000100, 8'h00, "unmapped_rd");
        chk("unmapped_rresp", rs, `IFS_RESP_SLVERR);
        $display("test registers done");
        foreach (flt_set[i]) filt_try(flt_set[i]);
        $display("test filter done");
        axi_wr(A_EN, 8'h01);
        axi_wr(A_FLT, 8'h01);
        bus_u.frame(8'hA6);
        repeat (20) @(posedge mclk);
        rchk(A_FLT, 8'h41, "stop_flag");
        rchk(A_STAT, 8'h04, "stop_gated");
        chk("irq_gated", irq, 1'b0);
        axi_wr(A_FLT, 8'h21);
        rchk(A_FLT, 8'h61, "stop_sticky");
        chk("irq_raised", irq, 1'b1);
        axi_wr(A_CLR, 8'h01);
        rchk(A_STAT, 8'h05, "flag_reassert");
        axi_wr(A_EN, 8'h00);
        chk("irq_masked", irq, 1'b0);
        axi_wr(A_EN, 8'h01);
        axi_wr(A_FLT, 8'h61);
        rchk(A_FLT, 8'h21, "stop_w1c");
        axi_wr(A_CLR, 8'h05);
        rchk(A_STAT, 8'h00, "flags_cleared");
        chk("irq_cleared", irq, 1'b0);
        $display("test stop detect done");
        axi_wr(A_CTRL, 8'h21);
        axi_wr(A_RA, 8'h30);
        foreach (addr_tab[i]) addr_try(addr_tab[i][6:0], addr_tab[i][7]);
        axi_wr(A_CTRL, 8'h20);
        addr_try(7'h11, 1'b0);
        addr_try(7'h18, 1'b1);
        addr_10bit <= 1'b1;
        addr_try(7'h18, 1'b0);
        addr_10bit <= 1'b0;
        axi_wr(A_RA, 8'h00);
        addr_try(7'h18, 1'b0);
        axi_wr(A_CLR, 8'h07);
        $display("test address match done");
        stop_try(8'h01, 1'b1, 0);
        // the cut transfer is restarted after wake by sending the slave address again
        addr_try(7'h10, 1'b1);
        axi_wr(A_CLR, 8'h02);
        stop_try(8'h81, 1'b1, 3);
        stop_try(8'h81, 1'b0, 0);
        rchk(A_STAT, 8'h01, "wake_irq");
        $display("test stop mode done");
        conclude();
    end
endmodule
